// File: ssa_pkg.sv
`default_nettype none
package ssa_pkg;
    // ----------------------------------------------------------------
    // Array geometry
    // ----------------------------------------------------------------
    localparam int SSA_ADDR_W = 19;
    localparam int SSA_LANES = 4;
    localparam int SSA_LANE_W = 9;
    // ----------------------------------------------------------------
    // Burst counter
    // ----------------------------------------------------------------
    localparam int SSA_BURST_W = 2;
    localparam logic [1:0] SSA_BURST_RST = 2'h0;
    localparam logic [1:0] SSA_BURST_STEP = 2'h1;
    localparam logic SSA_MODE_RST = 1'b1;
    // ----------------------------------------------------------------
    // Burst sequence types
    // ----------------------------------------------------------------
    typedef logic [SSA_BURST_W-1:0] ssa_beat_t;
endpackage
`default_nettype wire

// File: ssa_mem_if.sv
`default_nettype none
interface ssa_mem_if #(parameter int ADDR_W = 19, parameter int LANES = 4, parameter int LANE_W = 9);
    logic [ADDR_W-1:0] addr;
    logic [LANES*LANE_W-1:0] wdata;
    logic [LANES-1:0] lane_we;
    logic rd_en;
    logic [LANES*LANE_W-1:0] rdata;
    modport ctrl (output addr, output wdata, output lane_we, output rd_en, input rdata);
    modport mem (input addr, input wdata, input lane_we, input rd_en, output rdata);
endinterface
`default_nettype wire

// File: ssa_mem.sv
`default_nettype none
module ssa_mem #(
    parameter int ADDR_W = 19,
    parameter int LANES = 4,
    parameter int LANE_W = 9
) (
    // Clock
    input wire logic clk_sys,
    // Array port
    ssa_mem_if.mem bif
);
    logic [LANES*LANE_W-1:0] store_q [2**ADDR_W];
    logic [LANES*LANE_W-1:0] rdata_q;

    // ----------------------------------------------------------------
    // Byte-lane write, registered read
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < LANES; i++) begin
            if (bif.lane_we[i]) begin
                store_q[bif.addr][i*LANE_W +: LANE_W] <= bif.wdata[i*LANE_W +: LANE_W];
            end
        end
        if (bif.rd_en) begin
            rdata_q <= store_q[bif.addr];
        end
    end

    assign bif.rdata = rdata_q;
endmodule
`default_nettype wire

// File: ssa_sram_access.sv
// Overview of operation
// (RL1) All synchronous inputs are captured on the rising clock edge.
// (RL2) Burst mode input low gives linear order, high gives interleaved.
// (RL3) Two-bit wrapping counter captures first address and generates the rest.
// (RL4) Counter loads from the two lowest address bits; only those vary.
// (RL5) Burst address advances only under the burst advance input.
// (RL6) Byte-lane writes need byte write enable plus the selected lanes.
// (RL7) Global write writes all four lanes regardless of byte controls.
// (RL8) Selected only when first select low, second high, third low.
// (RL9) Read starts on either strobe with selects active; processor strobe needs first select.
// (RL10) Master keeps write controls off in the first controller-strobe read cycle; wr_lanes starts its read-back with byte write enable low, no lane selected.
// (RL11) With output enable low, read data flows out after the sampling edge.
// (RL12) Processor-strobe start ignores writes first cycle; next-edge writes are performed.
// (RL13) Data lines tri-state as soon as a write is seen, whatever output enable.
// (RL14) Master releases output enable before driving write data; ssa_master raises it in the same beat that drives the data.
// (RL15) Controller-strobe write starts same cycle; controller strobe ignored when processor strobe low.
// (RL16) Interleaved order is start address XOR beat index.
// (RL17) Scan port samples data and mode on rising scan clock, shifts out on falling.
// (RL18) Linear order is start address plus beat index, modulo four.
// (RL19) Write when global write low, or byte enable low with any lane.
// (RL20) Data outputs stay high impedance while deselected.
// (RL21) Advance high with no strobe repeats the access at the current address.
// (RL22) After the fourth beat the counter wraps to the first address.
`default_nettype none
module ssa_sram_access import ssa_pkg::*; #(
    parameter int ADDR_W = SSA_ADDR_W,
    parameter int LANES = SSA_LANES,
    parameter int LANE_W = SSA_LANE_W
) (
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    // Selects and strobes
    input wire logic chip_select_first_n,
    input wire logic chip_select_second,
    input wire logic chip_select_third_n,
    input wire logic processor_address_strobe_n,
    input wire logic controller_address_strobe_n,
    input wire logic burst_advance_n,
    // Write controls
    input wire logic global_write_n,
    input wire logic byte_write_enable_n,
    input wire logic [LANES-1:0] byte_lane_select_n,
    // Address, mode, output enable
    input wire logic [ADDR_W-1:0] addr,
    input wire logic mode,
    input wire logic output_enable_n,
    // Data pins
    input wire logic [LANES*LANE_W-1:0] dq_i,
    output logic [LANES*LANE_W-1:0] dq_o,
    output logic dq_oe,
    // Scan port
    input wire logic tck,
    input wire logic tdi,
    input wire logic tms,
    output logic tdo,
    output logic tdo_oe
);
    // ----------------------------------------------------------------
    // Burst address sequence
    // ----------------------------------------------------------------
    function automatic ssa_beat_t burst_addr(ssa_beat_t first, ssa_beat_t idx, logic interleave);
        burst_addr = interleave ? (first ^ idx) : ssa_beat_t'(first + idx);
    endfunction

    ssa_mem_if #(.ADDR_W(ADDR_W), .LANES(LANES), .LANE_W(LANE_W)) bif ();

    ssa_mem #(.ADDR_W(ADDR_W), .LANES(LANES), .LANE_W(LANE_W)) u_mem (
        .clk_sys(clk_sys),
        .bif(bif)
    );

    logic active_q;
    logic read_q;
    logic mode_q;
    logic strap_q;
    logic [ADDR_W-1:0] base_q;
    ssa_beat_t cnt_q;

    // ----------------------------------------------------------------
    // Cycle decode
    // ----------------------------------------------------------------
    wire sel_w = ~chip_select_first_n & chip_select_second & ~chip_select_third_n; // [RL8]
    wire processor_address_strobe_go_w = ~processor_address_strobe_n & ~chip_select_first_n; // [RL9]
    wire controller_address_strobe_go_w = ~controller_address_strobe_n & processor_address_strobe_n; // [RL15]
    wire strobe_w = processor_address_strobe_go_w | controller_address_strobe_go_w;
    wire start_w = strobe_w & sel_w; // [RL9]
    wire desel_w = strobe_w & ~sel_w;
    wire cont_w = active_q & ~strobe_w;
    wire adv_w = cont_w & ~burst_advance_n; // [RL5] [RL21]
    wire wr_req_w = ~global_write_n | (~byte_write_enable_n & |(~byte_lane_select_n)); // [RL19]
    wire start_wr_w = start_w & ~processor_address_strobe_go_w & wr_req_w; // [RL12] [RL15]
    wire wr_beat_w = start_wr_w | (cont_w & wr_req_w); // [RL12]
    wire rd_beat_w = (start_w | cont_w) & ~wr_beat_w;
    wire [LANES-1:0] lanes_w = ~global_write_n ? {LANES{1'b1}} : // [RL7]
                               (byte_write_enable_n ? {LANES{1'b0}} : ~byte_lane_select_n); // [RL6]

    // ----------------------------------------------------------------
    // Beat address
    // ----------------------------------------------------------------
    wire ssa_beat_t idx_w = adv_w ? ssa_beat_t'(cnt_q + SSA_BURST_STEP) : cnt_q; // [RL22]
    wire ssa_beat_t seq_lo_w = burst_addr(base_q[1:0], idx_w, mode_q); // [RL2] [RL16] [RL18]
    wire [ADDR_W-1:0] beat_addr_w = start_w ? addr : {base_q[ADDR_W-1:2], seq_lo_w}; // [RL4]

    assign bif.addr = beat_addr_w;
    assign bif.wdata = dq_i;
    assign bif.lane_we = (ce & wr_beat_w) ? lanes_w : {LANES{1'b0}};
    assign bif.rd_en = ce & rd_beat_w;

    // ----------------------------------------------------------------
    // Burst state
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            active_q <= 1'b0;
            read_q <= 1'b0;
            base_q <= '0;
            cnt_q <= SSA_BURST_RST;
        end else if (ce) begin
            if (start_w) begin
                base_q <= addr; // [RL1] [RL3]
                cnt_q <= SSA_BURST_RST;
            end else if (adv_w) begin
                cnt_q <= idx_w; // [RL5]
            end
            active_q <= start_w | (active_q & ~desel_w);
            read_q <= rd_beat_w; // [RL20]
        end
    end

    // Mode strap caught on the first enabled cycle after reset
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            strap_q <= 1'b0;
            mode_q <= SSA_MODE_RST;
        end else if (ce && !strap_q) begin
            strap_q <= 1'b1;
            mode_q <= mode; // [RL2]
        end
    end

    // ----------------------------------------------------------------
    // Data pins
    // ----------------------------------------------------------------
    assign dq_o = bif.rdata;
    assign dq_oe = read_q & ~output_enable_n & ~wr_req_w; // [RL11] [RL13]

    // ----------------------------------------------------------------
    // Scan port
    // ----------------------------------------------------------------
    logic tck_m_q;
    logic tck_s_q;
    logic tck_d_q;
    logic tdi_m_q;
    logic tdi_s_q;
    logic tms_m_q;
    logic tms_s_q;
    logic bypass_q;
    logic shift_q;
    logic tdo_q;
    logic tdo_oe_q;

    wire tck_rise_w = tck_s_q & ~tck_d_q;
    wire tck_fall_w = ~tck_s_q & tck_d_q;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            tck_m_q <= 1'b0;
            tck_s_q <= 1'b0;
            tck_d_q <= 1'b0;
            tdi_m_q <= 1'b0;
            tdi_s_q <= 1'b0;
            tms_m_q <= 1'b0;
            tms_s_q <= 1'b0;
        end else if (ce) begin
            tck_m_q <= tck;
            tck_s_q <= tck_m_q;
            tck_d_q <= tck_s_q;
            tdi_m_q <= tdi;
            tdi_s_q <= tdi_m_q;
            tms_m_q <= tms;
            tms_s_q <= tms_m_q;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            bypass_q <= 1'b0;
            shift_q <= 1'b0;
            tdo_q <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else if (ce) begin
            if (tck_rise_w) begin
                bypass_q <= tdi_s_q; // [RL17]
                shift_q <= ~tms_s_q;
            end
            if (tck_fall_w) begin
                tdo_q <= bypass_q; // [RL17]
                tdo_oe_q <= shift_q;
            end
        end
    end

    assign tdo = tdo_q;
    assign tdo_oe = tdo_oe_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    addr_capture_a: assert property (ce && start_w |=> base_q == $past(addr)) // [RL1]
        else $error("start address not captured");

    interleave_seq_a: assert property (ce && adv_w && mode_q |->
        bif.addr[1:0] == (base_q[1:0] ^ ssa_beat_t'(cnt_q + 2'h1))) // [RL16]
        else $error("interleaved beat address wrong");

    linear_seq_a: assert property (ce && adv_w && !mode_q |->
        bif.addr[1:0] == ssa_beat_t'(base_q[1:0] + cnt_q + 2'h1)) // [RL18]
        else $error("linear beat address wrong");

    upper_hold_a: assert property (ce && cont_w |-> bif.addr[ADDR_W-1:2] == base_q[ADDR_W-1:2]) // [RL4]
        else $error("upper address bits moved in burst");

    suspend_hold_a: assert property (ce && cont_w && burst_advance_n |=> cnt_q == $past(cnt_q)) // [RL21]
        else $error("counter moved without advance");

    counter_wrap_a: assert property (ce && adv_w && !start_w && cnt_q == 2'h3 |=> cnt_q == 2'h0) // [RL22]
        else $error("counter did not wrap");

    global_write_a: assert property (ce && wr_beat_w && !global_write_n |-> bif.lane_we == {LANES{1'b1}}) // [RL7]
        else $error("global write missed a lane");

    processor_first_a: assert property (ce && start_w && processor_address_strobe_go_w |-> bif.lane_we == '0 && bif.rd_en) // [RL12]
        else $error("write taken on processor strobe cycle");

    controller_write_a: assert property (ce && start_w && !processor_address_strobe_go_w && !global_write_n |->
        bif.lane_we != '0) // [RL15]
        else $error("controller strobe write not started");

    select_only_a: assert property (bif.lane_we != '0 && !active_q |-> sel_w) // [RL8]
        else $error("access while not selected");

    write_tristate_a: assert property (wr_req_w |-> !dq_oe) // [RL13]
        else $error("data driven during write");

    deselect_off_a: assert property (ce && desel_w |=> !dq_oe) // [RL20]
        else $error("data driven while deselected");

    read_drive_a: assert property (ce && rd_beat_w ##1 (!output_enable_n && !wr_req_w) |-> dq_oe) // [RL11]
        else $error("read data not driven");

    scan_sample_a: assert property (ce && tck_rise_w |=> bypass_q == $past(tdi_s_q)) // [RL17]
        else $error("scan input not sampled on rise");
endmodule
`default_nettype wire

// File: ssa_master.sv
`default_nettype none
module ssa_master (
    // Clock
    input wire logic clk_sys,
    // Bus pins toward the device
    output logic chip_select_second,
    output logic processor_address_strobe_n,
    output logic controller_address_strobe_n,
    output logic burst_advance_n,
    output logic global_write_n,
    output logic byte_write_enable_n,
    output logic [3:0] byte_lane_select_n,
    output logic [7:0] addr,
    output logic output_enable_n,
    output logic [35:0] dq_i
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        chip_select_second = 1'b0;
        processor_address_strobe_n = 1'b1;
        controller_address_strobe_n = 1'b0;
        burst_advance_n = 1'b1;
        global_write_n = 1'b1;
        byte_write_enable_n = 1'b1;
        byte_lane_select_n = 4'hF;
        addr = 8'h00;
        output_enable_n = 1'b1;
        dq_i = 36'h0;
    end

    // One beat, called at a falling edge; c = sel, strobes, advance, write
    task automatic beat(input logic [5:0] c, input logic [3:0] ln_n, input logic [7:0] a,
                        input logic [35:0] d);
        logic wr;
        wr = !c[1] || (!c[0] && ln_n != 4'hF);
        chip_select_second <= c[5];
        processor_address_strobe_n <= c[4];
        controller_address_strobe_n <= c[3];
        burst_advance_n <= c[2];
        global_write_n <= c[1];
        byte_write_enable_n <= c[0];
        byte_lane_select_n <= ln_n;
        addr <= a;
        output_enable_n <= wr;
        // Released data lines show the inverse of the last value
        dq_i <= wr ? d : ~dq_i;
    endtask
endmodule
`default_nettype wire

// File: tb_sync_burst_sram_access.sv
`default_nettype none
module tb_sync_burst_sram_access;
    timeunit 1ns;
    timeprecision 1ps;
    import ssa_pkg::*;
    logic clk_sys, rst_n, mode, tck, tdi, tms, dq_oe, tdo, tdo_oe;
    logic chip_select_first_n, chip_select_third_n;
    logic chip_select_second, processor_address_strobe_n, controller_address_strobe_n;
    logic burst_advance_n, global_write_n, byte_write_enable_n, output_enable_n;
    logic [3:0] byte_lane_select_n;
    logic [7:0] addr;
    logic [35:0] dq_i, dq_o;
    int errors = 0;
    int n_compared = 0;

    ssa_master i_master (.clk_sys, .chip_select_second, .processor_address_strobe_n,
        .controller_address_strobe_n, .burst_advance_n, .global_write_n, .byte_write_enable_n,
        .byte_lane_select_n, .addr, .output_enable_n, .dq_i);
    ssa_sram_access #(.ADDR_W(8)) i_dut (.clk_sys, .rst_n, .ce(1'b1), .chip_select_first_n,
        .chip_select_second, .chip_select_third_n, .processor_address_strobe_n,
        .controller_address_strobe_n, .burst_advance_n, .global_write_n, .byte_write_enable_n,
        .byte_lane_select_n, .addr, .mode, .output_enable_n, .dq_i, .dq_o, .dq_oe, .tck, .tdi,
        .tms, .tdo, .tdo_oe);

    task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        if (errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    function automatic logic [35:0] pat(input logic [1:0] i);
        return {4{7'h5A, i}};
    endfunction

    task automatic do_reset(input logic m);
        @(negedge clk_sys);
        rst_n <= 1'b0;
        mode <= m;
        repeat (12) @(negedge clk_sys);
        rst_n <= 1'b1;
    endtask

    task automatic fill();
        for (int i = 0; i < 4; i++) begin
            @(negedge clk_sys);
            i_master.beat(6'b110101, 4'hF, 8'hA4 | 8'(i), pat(2'(i)));
        end
    endtask

    // Burst with wrap, then one suspended beat, then deselect
    task automatic rd_burst(input logic [1:0] st, input logic ilv);
        logic [1:0] k;
        @(negedge clk_sys);
        i_master.beat(6'b101111, 4'hF, 8'hA4 | 8'(st), 36'h0);
        for (int i = 0; i < 7; i++) begin
            k = 2'(i == 6 ? 5 : i);
            @(negedge clk_sys);
            check("burst data", dq_o, pat(ilv ? st ^ k : st + k));
            check("burst drive", {35'h0, dq_oe}, 36'h1);
            i_master.beat(i == 5 ? 6'b111111 : 6'b111011, 4'hF, 8'hFF, 36'h0);
        end
        @(negedge clk_sys);
        i_master.beat(6'b010111, 4'hF, 8'h00, 36'h0);
        @(negedge clk_sys);
        check("deselect drive", {35'h0, dq_oe}, 36'h0);
    endtask

    task automatic wr_lanes();
        logic [35:0] m;
        m = {9'h0, 9'h1FF, 9'h0, 9'h1FF};
        @(negedge clk_sys);
        i_master.beat(6'b110110, 4'hA, 8'hA4, '1);
        #1 check("write drive", {35'h0, dq_oe}, 36'h0);
        @(negedge clk_sys);
        i_master.beat(6'b110110, 4'hF, 8'hA4, 36'h0);
        @(negedge clk_sys);
        i_master.beat(6'b101101, 4'hF, 8'hA7, 36'h0);
        check("lane data", dq_o, (pat(2'h0) & ~m) | m);
        @(negedge clk_sys);
        check("first cycle", dq_o, pat(2'h3));
        i_master.beat(6'b111101, 4'hF, 8'hFF, 36'h0_1234_5678);
        // Output enable forced low on a write beat after a read: drive must stay off
        #1 i_master.output_enable_n = 1'b0;
        #1 check("masked drive", {35'h0, dq_oe}, 36'h0);
        i_master.output_enable_n = 1'b1;
        @(negedge clk_sys);
        i_master.beat(6'b101111, 4'hF, 8'hA7, 36'h0);
        @(negedge clk_sys);
        check("late write", dq_o, 36'h0_1234_5678);
    endtask

    task automatic scan();
        for (int i = 0; i < 2; i++) begin
            tms <= i[0];
            tdi <= !i[0];
            repeat (5) @(negedge clk_sys);
            tck <= 1'b1;
            repeat (5) @(negedge clk_sys);
            check("scan hold", {34'h0, tdo_oe, tdo}, {34'h0, i[0], i[0]});
            tck <= 1'b0;
            repeat (6) @(negedge clk_sys);
            check("scan out", {34'h0, tdo_oe, tdo}, {34'h0, !i[0], !i[0]});
        end
    endtask

    // Processor strobe without first select continues; third select off deselects
    task automatic sel_gate();
        @(negedge clk_sys);
        i_master.beat(6'b101111, 4'hF, 8'hA4, 36'h0);
        @(negedge clk_sys);
        check("start data", dq_o, pat(2'h0));
        chip_select_first_n <= 1'b1;
        i_master.beat(6'b101011, 4'h0, 8'hA6, 36'h0);
        @(negedge clk_sys);
        check("ignored strobe", dq_o, pat(2'h1));
        chip_select_first_n <= 1'b0;
        chip_select_third_n <= 1'b1;
        i_master.beat(6'b101111, 4'hF, 8'hA6, 36'h0);
        @(negedge clk_sys);
        check("third select data", dq_o, pat(2'h1));
        check("third select drive", {35'h0, dq_oe}, 36'h0);
        chip_select_third_n <= 1'b0;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial begin
        #200000;
        errors++;
        close_out();
    end

    initial begin
        rst_n = 1'b0;
        mode = 1'b0;
        tck = 1'b0;
        tdi = 1'b0;
        tms = 1'b1;
        chip_select_first_n = 1'b0;
        chip_select_third_n = 1'b0;
        do_reset(1'b0);
        fill();
        rd_burst(2'h1, 1'b0);
        wr_lanes();
        scan();
        do_reset(1'b1);
        fill();
        rd_burst(2'h3, 1'b1);
        sel_gate();
        close_out();
    end
endmodule
`default_nettype wire
